//--- common/cam_pkg.sv
// Constants, types and helpers of the channel 2 multi-role input block.
// Assumes an APB master on mclk_in and link clocks arriving from pins.
// How it works
// R01: Telecom bus enable gives the pin its alarm role
// R02: Source raises alarm while AIS-carrying signal is added
// R03: Sampled alarm high declares path AIS defect
// R04: Bus disabled: channel mode picks the role
// R05: Pin held low in STS-1 mode
// R06: Single-rail: pin is the line code violation
// R07: Violation sampled on configured line clock edge
// R08: Sampled violations bump violation or zeros counters
// R09: Dual-rail: pin carries negative rail data
// R10: Add bus input latched on falling clock edge
// R11: Unselected roles declare nothing, count nothing
`default_nettype none
package cam_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [7:0]  LCV_CNT_OFS   = 8'h08;
  localparam logic [7:0]  EXZ_CNT_OFS   = 8'h0c;
  localparam logic [7:0]  AIS_CNT_OFS   = 8'h10;
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned CTRL_TBUS_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_MODE_W   = 2;
  localparam int unsigned CTRL_FALL_BIT = 3;
  localparam int unsigned CTRL_EXZ_BIT  = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int unsigned STAT_AIS_BIT  = 0;
  localparam int unsigned STAT_LIVE_BIT = 1;
  localparam int unsigned GRAY_W        = 4;

  typedef logic [GRAY_W-1:0] cam_gray_t;

  typedef enum logic [CTRL_MODE_W-1:0] {
    CAM_MODE_STS1   = 2'h0,
    CAM_MODE_SINGLE = 2'h1,
    CAM_MODE_DUAL   = 2'h2
  } cam_mode_t;

  typedef enum logic [1:0] {
    CAM_BUS_IDLE = 2'h1,
    CAM_BUS_RESP = 2'h2
  } cam_bus_t;

  function automatic cam_gray_t bin2gray(input cam_gray_t b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic cam_gray_t gray2bin(input cam_gray_t g);
    cam_gray_t b;
    b = '0;
    for (int i = GRAY_W - 1; i >= 0; i--) begin
      b[i] = (i == GRAY_W - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    gray2bin = b;
  endfunction
endpackage
`default_nettype wire

//--- common/cam_link_if.sv
// Signals between the core and one link-side capture stage.
// Controls are mclk flops or a constant; sample and gray count are link flops.
`timescale 1ns/1ps
`default_nettype none
interface cam_link_if;
  logic              data_en;
  logic              count_en;
  logic              edge_fall;
  logic              sample;
  cam_pkg::cam_gray_t gray;

  modport cap (
    input  data_en, count_en, edge_fall,
    output sample, gray
  );
  modport core (
    output data_en, count_en, edge_fall,
    input  sample, gray
  );
endinterface
`default_nettype wire

//--- core/cam_capture.sv
// Link-side capture: samples the pin on a chosen edge, counts highs.
// Assumes controls and srst_in are levels from the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module cam_capture (
  input  wire logic link_clk_in, // Link clock
  input  wire logic srst_in,     // Reset, mclk domain level
  input  wire logic pin_in,      // Pin, synchronous to link clock
  cam_link_if.cap   lnk          // Controls in, sample and count out
);
  logic [1:0]         rst_sync_reg;
  logic [1:0]         den_sync_reg;
  logic [1:0]         cen_sync_reg;
  logic [1:0]         fall_sync_reg;
  logic               rise_smp_reg;
  logic               fall_smp_reg;
  logic               sample_reg;
  cam_pkg::cam_gray_t bin_reg;
  cam_pkg::cam_gray_t gray_reg;
  wire                link_rst;
  wire                smp;
  wire                hit;
  wire cam_pkg::cam_gray_t bin_next;

  assign link_rst = rst_sync_reg[1];
  assign smp      = fall_sync_reg[1] ? fall_smp_reg : rise_smp_reg; // R07
  assign hit      = cen_sync_reg[1] & smp;
  assign bin_next = bin_reg + cam_pkg::cam_gray_t'(1);

  // Mclk-domain levels brought in by two flops each
  always_ff @(posedge link_clk_in) begin
    rst_sync_reg  <= {rst_sync_reg[0], srst_in};
    den_sync_reg  <= {den_sync_reg[0], lnk.data_en};
    cen_sync_reg  <= {cen_sync_reg[0], lnk.count_en};
    fall_sync_reg <= {fall_sync_reg[0], lnk.edge_fall};
  end

  always_ff @(negedge link_clk_in) begin
    fall_smp_reg <= pin_in; // R10
  end

  always_ff @(posedge link_clk_in) begin
    rise_smp_reg <= pin_in;
  end

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      sample_reg <= 1'b0;
      bin_reg    <= '0;
      gray_reg   <= '0;
    end else begin
      sample_reg <= den_sync_reg[1] & smp; // R11
      if (hit) begin // R02
        bin_reg  <= bin_next;
        gray_reg <= cam_pkg::bin2gray(bin_next);
      end
    end
  end

  assign lnk.sample = sample_reg;
  assign lnk.gray   = gray_reg;
endmodule
`default_nettype wire

//--- core/cam_ch2_input.sv
// Channel 2 multi-role input: path alarm, violation or negative rail.
// Assumes an APB master on mclk_in; link clocks come from the pins.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cam_ch2_input #(
  parameter int unsigned CNT_W = 16 // Event counter width
) (
  input  wire logic        mclk_in,               // System clock
  input  wire logic        srst_in,               // Sync reset, high
  input  wire logic        add_bus_clock_in,      // Add bus clock
  input  wire logic        rx_line_clock_in,      // Receive line clock
  input  wire logic        add_bus_path_alarm_in, // Multi-role pin
  input  wire logic        psel_in,               // APB select
  input  wire logic        penable_in,            // APB enable
  input  wire logic        pwrite_in,             // APB direction
  input  wire logic [7:0]  paddr_in,              // APB byte address
  input  wire logic [31:0] pwdata_in,             // APB write data
  output logic      [31:0] prdata_out,            // APB read data
  output logic             pready_out,            // APB ready
  output logic             pslverr_out,           // APB error
  output logic             path_ais_defect_out,   // Sticky AIS defect
  output logic             lcv_event_out,         // Violation seen
  output logic             rx_line_negative_rail_out // Neg rail data
);
  generate
    if (CNT_W < cam_pkg::GRAY_W + 1 || CNT_W > cam_pkg::DATA_W) begin
      $error("CNT_W out of range");
    end
  endgenerate

  // Saturating add of a small delta
  function automatic logic [CNT_W-1:0] bump(
    input logic [CNT_W-1:0] v,
    input cam_pkg::cam_gray_t d
  );
    logic [CNT_W:0] s;
    s    = {1'b0, v} + (CNT_W+1)'(d);
    bump = s[CNT_W] ? '1 : s[CNT_W-1:0];
  endfunction

  cam_link_if add_if ();
  cam_link_if line_if ();

  cam_capture u_add_cap (
    .link_clk_in (add_bus_clock_in),
    .srst_in     (srst_in),
    .pin_in      (add_bus_path_alarm_in),
    .lnk         (add_if.cap)
  );

  cam_capture u_line_cap (
    .link_clk_in (rx_line_clock_in),
    .srst_in     (srst_in),
    .pin_in      (add_bus_path_alarm_in),
    .lnk         (line_if.cap)
  );

  // Register state
  cam_pkg::cam_bus_t             bus_reg;
  cam_pkg::cam_bus_t             bus_next;
  logic [cam_pkg::CTRL_W-1:0]    ctrl_reg;
  logic [CNT_W-1:0]              lcv_cnt_reg;
  logic [CNT_W-1:0]              exz_cnt_reg;
  logic [CNT_W-1:0]              ais_cnt_reg;
  logic [CNT_W-1:0]              lcv_cnt_next;
  logic [CNT_W-1:0]              exz_cnt_next;
  logic [CNT_W-1:0]              ais_cnt_next;
  logic                          ais_defect_reg;
  logic                          ais_defect_next;
  logic                          lcv_event_reg;
  logic [31:0]                   prdata_reg;
  logic                          pready_reg;
  logic                          pslverr_reg;

  // Role controls, registered before they cross
  logic                          add_en_reg;
  logic                          single_en_reg;
  logic                          dual_en_reg;
  logic                          fall_reg;

  // Gray count synchronisers and history
  cam_pkg::cam_gray_t            ais_g1_reg;
  cam_pkg::cam_gray_t            ais_g2_reg;
  cam_pkg::cam_gray_t            lcv_g1_reg;
  cam_pkg::cam_gray_t            lcv_g2_reg;
  cam_pkg::cam_gray_t            ais_prev_reg;
  cam_pkg::cam_gray_t            lcv_prev_reg;
  logic [1:0]                    live_sync_reg;

  // Configuration fields
  wire                           tbus_en;
  wire cam_pkg::cam_mode_t       mode;
  wire                           edge_fall;
  wire                           exz_sel;
  wire                           role_alarm;
  wire                           role_single;
  wire                           role_dual;

  assign tbus_en    = ctrl_reg[cam_pkg::CTRL_TBUS_BIT];
  assign mode       = cam_pkg::cam_mode_t'(
                        ctrl_reg[cam_pkg::CTRL_MODE_LSB +:
                                 cam_pkg::CTRL_MODE_W]);
  assign edge_fall  = ctrl_reg[cam_pkg::CTRL_FALL_BIT];
  assign exz_sel    = ctrl_reg[cam_pkg::CTRL_EXZ_BIT];
  assign role_alarm = tbus_en; // R01
  assign role_single = !tbus_en &&
                       (mode == cam_pkg::CAM_MODE_SINGLE); // R04
  assign role_dual   = !tbus_en &&
                       (mode == cam_pkg::CAM_MODE_DUAL); // R04

  // Capture controls; with the bus disabled, STS-1 mode leaves both captures idle
  assign add_if.data_en    = add_en_reg;
  assign add_if.count_en   = add_en_reg;
  assign add_if.edge_fall  = 1'b1; // R10
  assign line_if.data_en   = dual_en_reg; // R09
  assign line_if.count_en  = single_en_reg; // R06
  assign line_if.edge_fall = fall_reg; // R07

  // Event deltas seen in the system domain
  wire cam_pkg::cam_gray_t       ais_bin;
  wire cam_pkg::cam_gray_t       lcv_bin;
  wire cam_pkg::cam_gray_t       ais_delta;
  wire cam_pkg::cam_gray_t       lcv_delta;
  wire cam_pkg::cam_gray_t       ais_inc;
  wire cam_pkg::cam_gray_t       lcv_inc;
  wire cam_pkg::cam_gray_t       exz_inc;
  wire                           ais_seen;
  wire                           lcv_seen;

  assign ais_bin   = cam_pkg::gray2bin(ais_g2_reg);
  assign lcv_bin   = cam_pkg::gray2bin(lcv_g2_reg);
  assign ais_delta = ais_bin - ais_prev_reg;
  assign lcv_delta = lcv_bin - lcv_prev_reg;
  assign ais_inc   = role_alarm ? ais_delta : '0; // R11
  assign lcv_inc   = (role_single && !exz_sel) ? lcv_delta : '0; // R08
  assign exz_inc   = (role_single && exz_sel) ? lcv_delta : '0; // R08
  assign ais_seen  = (ais_inc != '0);
  assign lcv_seen  = role_single && (lcv_delta != '0); // R11

  // APB decode
  wire                           setup;
  wire                           access;
  wire                           wr_done;
  wire                           hit_ctrl;
  wire                           hit_stat;
  wire                           hit_lcv;
  wire                           hit_exz;
  wire                           hit_ais;
  wire                           hit_any;
  wire                           wr_ctrl;
  wire                           wr_stat;
  wire                           clr_lcv;
  wire                           clr_exz;
  wire                           clr_ais;
  wire                           ais_w1c;
  wire [31:0]                    ctrl_word;
  wire [31:0]                    stat_word;
  wire [31:0]                    rd_word;

  assign setup    = psel_in && !penable_in &&
                    (bus_reg == cam_pkg::CAM_BUS_IDLE);
  assign access   = psel_in && penable_in &&
                    (bus_reg == cam_pkg::CAM_BUS_RESP);
  assign wr_done  = access && pwrite_in && pready_reg;
  assign hit_ctrl = (paddr_in == cam_pkg::CTRL_OFS);
  assign hit_stat = (paddr_in == cam_pkg::STAT_OFS);
  assign hit_lcv  = (paddr_in == cam_pkg::LCV_CNT_OFS);
  assign hit_exz  = (paddr_in == cam_pkg::EXZ_CNT_OFS);
  assign hit_ais  = (paddr_in == cam_pkg::AIS_CNT_OFS);
  assign hit_any  = hit_ctrl | hit_stat | hit_lcv | hit_exz | hit_ais;
  assign wr_ctrl  = wr_done && hit_ctrl;
  assign wr_stat  = wr_done && hit_stat;
  assign clr_lcv  = wr_done && hit_lcv;
  assign clr_exz  = wr_done && hit_exz;
  assign clr_ais  = wr_done && hit_ais;
  assign ais_w1c  = wr_stat && pwdata_in[cam_pkg::STAT_AIS_BIT];

  assign ctrl_word = 32'(ctrl_reg);
  assign stat_word =
    (32'(ais_defect_reg)   << cam_pkg::STAT_AIS_BIT) |
    (32'(live_sync_reg[1]) << cam_pkg::STAT_LIVE_BIT);
  assign rd_word =
    hit_ctrl ? ctrl_word :
    hit_stat ? stat_word :
    hit_lcv  ? 32'(lcv_cnt_reg) :
    hit_exz  ? 32'(exz_cnt_reg) :
    hit_ais  ? 32'(ais_cnt_reg) : 32'h0000_0000;

  // Bus sequencing: ready in the first access cycle
  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      cam_pkg::CAM_BUS_IDLE: begin
        if (setup) begin
          bus_next = cam_pkg::CAM_BUS_RESP;
        end
      end
      cam_pkg::CAM_BUS_RESP: begin
        bus_next = cam_pkg::CAM_BUS_IDLE;
      end
      default: begin
        bus_next = cam_pkg::CAM_BUS_IDLE;
      end
    endcase
  end

  // Defect sets win over a clear in the same cycle
  assign ais_defect_next = ais_seen | (ais_defect_reg & !ais_w1c); // R03

  assign ais_cnt_next = bump(clr_ais ? '0 : ais_cnt_reg, ais_inc);
  assign lcv_cnt_next = bump(clr_lcv ? '0 : lcv_cnt_reg, lcv_inc);
  assign exz_cnt_next = bump(clr_exz ? '0 : exz_cnt_reg, exz_inc);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      bus_reg     <= cam_pkg::CAM_BUS_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      bus_reg     <= bus_next;
      pready_reg  <= setup;
      pslverr_reg <= setup && !hit_any;
      if (setup) begin
        prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_word;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_reg      <= cam_pkg::CTRL_RST;
      add_en_reg    <= 1'b0;
      single_en_reg <= 1'b0;
      dual_en_reg   <= 1'b0;
      fall_reg      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata_in[cam_pkg::CTRL_W-1:0];
      end
      add_en_reg    <= role_alarm;
      single_en_reg <= role_single;
      dual_en_reg   <= role_dual;
      fall_reg      <= edge_fall;
    end
  end

  // Gray counts cross by two flops, then are differenced
  always_ff @(posedge mclk_in) begin
    ais_g1_reg    <= add_if.gray;
    ais_g2_reg    <= ais_g1_reg;
    lcv_g1_reg    <= line_if.gray;
    lcv_g2_reg    <= lcv_g1_reg;
    live_sync_reg <= {live_sync_reg[0], add_if.sample};
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ais_prev_reg   <= '0;
      lcv_prev_reg   <= '0;
      ais_defect_reg <= 1'b0;
      lcv_event_reg  <= 1'b0;
      ais_cnt_reg    <= '0;
      lcv_cnt_reg    <= '0;
      exz_cnt_reg    <= '0;
    end else begin
      ais_prev_reg   <= ais_bin;
      lcv_prev_reg   <= lcv_bin;
      ais_defect_reg <= ais_defect_next; // R03
      lcv_event_reg  <= lcv_seen; // R06
      ais_cnt_reg    <= ais_cnt_next;
      lcv_cnt_reg    <= lcv_cnt_next; // R08
      exz_cnt_reg    <= exz_cnt_next; // R08
    end
  end

  assign prdata_out                = prdata_reg;
  assign pready_out                = pready_reg;
  assign pslverr_out               = pslverr_reg;
  assign path_ais_defect_out       = ais_defect_reg;
  assign lcv_event_out             = lcv_event_reg;
  assign rx_line_negative_rail_out = line_if.sample; // R09
endmodule
`default_nettype wire

//--- sim/cam_far_end.sv
// Far-end model: add bus source and line interface driving the pin.
// Assumes the bench calls its tasks and makes both link clocks.
`timescale 1ns/1ps
`default_nettype none
module cam_far_end (
  input  wire logic add_clk_in,  // Add bus clock
  input  wire logic line_clk_in, // Receive line clock
  output logic      pin_out      // Multi-role pin
);
  initial pin_out = 1'b0;

  // Changes on rising edge, so stable at the falling sample
  task automatic alarm(input int n);
    repeat (n) begin
      @(posedge add_clk_in);
      pin_out <= 1'b1;
    end
    @(posedge add_clk_in);
    pin_out <= 1'b0;
  endtask

  // Drives on the edge opposite to the sampling edge
  task automatic viol(input int n, input bit fall);
    repeat (n + 1) begin
      if (fall) @(posedge line_clk_in);
      else @(negedge line_clk_in);
      pin_out <= (n > 0);
      n--;
    end
  endtask

  task automatic rail(input logic b);
    @(negedge line_clk_in);
    pin_out <= b;
  endtask
endmodule
`default_nettype wire

//--- sim/cam_ch2_input_properties.sv
// Port-level checker of the channel 2 multi-role input block.
// Assumes a bind into cam_ch2_input; shadows CTRL from APB writes.
`timescale 1ns/1ps
`default_nettype none
module cam_ch2_input_chk #(
  parameter int unsigned CNT_W = 16 // Event counter width
) (
  input wire logic        mclk_in,                  // System clock
  input wire logic        srst_in,                  // Sync reset
  input wire logic        psel_in,                  // APB select
  input wire logic        penable_in,               // APB enable
  input wire logic        pwrite_in,                // APB direction
  input wire logic [7:0]  paddr_in,                 // APB address
  input wire logic [31:0] pwdata_in,                // APB write data
  input wire logic [31:0] prdata_out,               // APB read data
  input wire logic        pready_out,               // APB ready
  input wire logic        pslverr_out,              // APB error
  input wire logic        path_ais_defect_out,      // AIS defect
  input wire logic        lcv_event_out,            // Violation seen
  input wire logic        rx_line_negative_rail_out // Neg rail
);
  localparam int SETTLE = 16;
  logic [4:0] ctrl_q;
  logic [4:0] off_cnt;
  logic [4:0] nsr_cnt;
  logic [4:0] ndr_cnt;
  wire setup  = psel_in && !penable_in;
  wire wr_end = psel_in && penable_in && pready_out && pwrite_in;
  wire mapped = paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  wire is_off = !ctrl_q[0];
  wire is_sr  = is_off && (ctrl_q[2:1] == 2'h1);
  wire is_dr  = is_off && (ctrl_q[2:1] == 2'h2);
  wire clr    = wr_end && (paddr_in == cam_pkg::STAT_OFS) && pwdata_in[0];

  // Cycles spent in a role that forbids each output
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_q  <= 5'h00;
      off_cnt <= 5'h00;
      nsr_cnt <= 5'h00;
      ndr_cnt <= 5'h00;
    end else begin
      if (wr_end && paddr_in == cam_pkg::CTRL_OFS) ctrl_q <= pwdata_in[4:0];
      off_cnt <= !is_off ? 5'h00 : off_cnt + 5'(off_cnt != 5'h1f);
      nsr_cnt <= is_sr ? 5'h00 : nsr_cnt + 5'(nsr_cnt != 5'h1f);
      ndr_cnt <= is_dr ? 5'h00 : ndr_cnt + 5'(ndr_cnt != 5'h1f);
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  ready_after_setup_a: assert property (setup |=> pready_out)
    else $error("no ready after setup");
  ready_cause_a: assert property (!setup |=> !pready_out)
    else $error("ready without setup");
  err_on_map_a: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("error flag wrong for address");
  read_zero_a: assert property
    (pready_out && (pwrite_in || pslverr_out) |-> prdata_out == 32'h0)
    else $error("data not zero");
  ctrl_read_a: assert property (
    pready_out && !pwrite_in && paddr_in == cam_pkg::CTRL_OFS
    |-> prdata_out == {27'h0, ctrl_q}) else $error("control readback");
  stat_mirror_a: assert property (
    pready_out && !pwrite_in && paddr_in == cam_pkg::STAT_OFS
    |-> prdata_out[0] == $past(path_ais_defect_out))
    else $error("status bit differs from defect");
  defect_hold_a: assert property (
    path_ais_defect_out && !clr |=> path_ais_defect_out)
    else $error("defect dropped without clear");
  no_ais_off_a: assert property (
    $rose(path_ais_defect_out) |-> off_cnt < SETTLE)
    else $error("defect with bus disabled");
  no_lcv_a: assert property (lcv_event_out |-> nsr_cnt < SETTLE)
    else $error("violation outside single rail");
  rail_idle_a: assert property (
    rx_line_negative_rail_out |-> ndr_cnt < SETTLE)
    else $error("rail high outside dual rail");

  cover property (wr_end && paddr_in == cam_pkg::CTRL_OFS);
  cover property ($rose(path_ais_defect_out));
  cover property (lcv_event_out);
  cover property (pready_out && pslverr_out);
endmodule

bind cam_ch2_input cam_ch2_input_chk #(.CNT_W(CNT_W)) chk (
  .mclk_in(mclk_in), .srst_in(srst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .path_ais_defect_out(path_ais_defect_out),
  .lcv_event_out(lcv_event_out),
  .rx_line_negative_rail_out(rx_line_negative_rail_out));
`default_nettype wire

//--- sim/test_ch2_alarm_lcv_neg_input_select.sv
// Bench of the channel 2 multi-role input: APB tasks and far-end model.
// Assumes cam_far_end drives the pin; link clocks free-running, 32 ns.
`timescale 1ns/1ps
`default_nettype none
module test_ch2_alarm_lcv_neg_input_select;
  logic        mclk, srst, add_clk, line_clk, pin;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic        defect, lcv_ev, neg_rail;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pat = 8'h5b;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          lcv_hits = 0;

  cam_ch2_input #(.CNT_W(16)) uut (
    .mclk_in(mclk), .srst_in(srst), .add_bus_clock_in(add_clk),
    .rx_line_clock_in(line_clk), .add_bus_path_alarm_in(pin),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .path_ais_defect_out(defect), .lcv_event_out(lcv_ev),
    .rx_line_negative_rail_out(neg_rail));
  cam_far_end far (.add_clk_in(add_clk), .line_clk_in(line_clk),
    .pin_out(pin));

  initial begin mclk = 0; forever #25 mclk = ~mclk; end
  initial begin add_clk = 0; #7; forever #16 add_clk = ~add_clk; end
  initial begin line_clk = 0; #13; forever #16 line_clk = ~line_clk; end

  task automatic close_out;
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // Entered and left just after a rising mclk edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic experr);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
    chk_bit(er, experr);
  endtask

  task automatic settle;
    repeat (24) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (lcv_ev === 1'b1) lcv_hits <= lcv_hits + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out;
    end
  end

  initial begin
    srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    apb(1'b1, 8'h14, 32'h1f);
    rd_chk(cam_pkg::CTRL_OFS, 32'h0, 1'b0);
    apb(1'b1, cam_pkg::CTRL_OFS, 32'hffffffff);
    rd_chk(cam_pkg::CTRL_OFS, 32'h1f, 1'b0);
    apb(1'b1, cam_pkg::CTRL_OFS, 32'h0);
    settle;
    chk_bit(neg_rail, 1'b0);
    apb(1'b1, cam_pkg::CTRL_OFS, 32'h1);
    settle;
    far.alarm(3);
    settle;
    chk_bit(defect, 1'b1);
    rd_chk(cam_pkg::STAT_OFS, 32'h1, 1'b0);
    rd_chk(cam_pkg::AIS_CNT_OFS, 32'h3, 1'b0);
    apb(1'b1, cam_pkg::STAT_OFS, 32'h1);
    rd_chk(cam_pkg::STAT_OFS, 32'h0, 1'b0);
    apb(1'b1, cam_pkg::AIS_CNT_OFS, 32'h0);
    apb(1'b1, cam_pkg::CTRL_OFS, 32'h4);
    settle;
    far.alarm(2);
    settle;
    rd_chk(cam_pkg::STAT_OFS, 32'h0, 1'b0);
    rd_chk(cam_pkg::AIS_CNT_OFS, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      far.rail(pat[i]);
      // Sampled on one rising edge, shown after the next
      @(posedge line_clk);
      @(posedge line_clk);
      @(negedge line_clk);
      chk_bit(neg_rail, pat[i]);
    end
    far.rail(1'b0);
    chk_word(32'(lcv_hits), 32'h0);
    apb(1'b1, cam_pkg::CTRL_OFS, 32'h2);
    settle;
    far.viol(5, 1'b0);
    settle;
    rd_chk(cam_pkg::LCV_CNT_OFS, 32'h5, 1'b0);
    rd_chk(cam_pkg::EXZ_CNT_OFS, 32'h0, 1'b0);
    chk_bit(lcv_hits >= 1 && lcv_hits <= 5, 1'b1);
    apb(1'b1, cam_pkg::CTRL_OFS, 32'h1a);
    settle;
    far.viol(4, 1'b1);
    settle;
    rd_chk(cam_pkg::EXZ_CNT_OFS, 32'h4, 1'b0);
    rd_chk(cam_pkg::LCV_CNT_OFS, 32'h5, 1'b0);
    rd_chk(cam_pkg::AIS_CNT_OFS, 32'h0, 1'b0);
    apb(1'b1, cam_pkg::LCV_CNT_OFS, 32'h0);
    rd_chk(cam_pkg::LCV_CNT_OFS, 32'h0, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
